// ### rtl/frc_ctrl.sv
`timescale 1ns/1ps
module frc_ctrl
	import frc_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic             WB_ACK_O,
	output logic      [31:0] WB_DAT_O,
	// Pipeline flag access
	input  wire logic        RETIRE,
	input  wire logic        FLAG_WR,
	input  wire logic [31:0] FLAG_WDATA,
	input  wire logic        STAT_WE,
	input  wire logic [5:0]  STAT_VAL,
	input  wire logic [1:0]  VIEW_SEL,
	output logic      [63:0] FLAGS_VIEW,
	// Event requests
	input  wire logic        EXT_INT,
	input  wire logic        NMI_REQ,
	input  wire logic        SWI_REQ,
	input  wire logic        EXC_REQ,
	input  wire logic        IO_REQ,
	// Event answers
	output logic             DBG_EXC,
	output logic             GP_FAULT,
	output logic             IO_GRANT,
	output logic             INT_ACCEPT,
	output logic             EVT_DELIVER,
	output logic             IRQ
);

	// All block state
	typedef struct packed {
		logic [31:0]       flags;  // Flags word, low half
		logic [CTX_W-1:0]  ctx;    // Privilege and mode context
		logic [IRQ_W-1:0]  ist;    // Sticky event status
		logic [IRQ_W-1:0]  ien;    // Event enables
		logic              ack;    // Bus acknowledge
		logic [31:0]       rdat;   // Bus read data
		logic              dbg;    // Debug exception pulse
		logic              gp;     // Protection fault pulse
		logic              iog;    // I/O grant pulse
		logic              iacc;   // Interrupt accepted pulse
		logic              dlv;    // Event delivered pulse
		logic [63:0]       view;   // Sized flags view
		logic              irq;    // Interrupt line
	} frc_state_t;

	frc_state_t s;       // Registered state
	frc_state_t next_s;  // Next state

	// Byte-lane merge of a bus write
	function automatic logic [31:0] sel_merge(
		input logic [31:0] old,
		input logic [31:0] d,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : sel_merge

	// Privilege-aware write of the flags word
	function automatic logic [31:0] wr_flags(
		input logic [31:0]      old,
		input logic [31:0]      d,
		input logic [CTX_W-1:0] ctx
	);
		logic [31:0] m;
		logic [31:0] r;
		logic [1:0]  lvl;
		logic [1:0]  fld;
		logic        virt;
		m    = FLAGS_USR_MASK;
		lvl  = ctx[CTX_PRIV +: 2];
		fld  = old[FB_IOPRIV +: 2];
		virt = ctx[CTX_VME] | ctx[CTX_PVI];
		// Only the top privilege changes the I/O field and mode bit
		if (lvl == 2'h0) begin
			m[FB_IOPRIV +: 2] = 2'h3;
			m[FB_V86]         = 1'b1;
		end
		r = (old & ~m) | (d & m);
		// Interrupt enable or its virtual copy
		if (virt && (fld != 2'h3)) begin
			r[FB_INTEN] = old[FB_INTEN];
			r[FB_VINT]  = d[FB_INTEN];
		end else if (lvl <= fld) begin
			r[FB_INTEN] = d[FB_INTEN];
		end else begin
			r[FB_INTEN] = old[FB_INTEN];
		end
		// Reserved bits forced, flags at fixed positions
		return (r & FLAGS_RW_MASK) | FLAGS_ONE_MASK;
	endfunction : wr_flags

	// Decoded context
	logic [1:0] priv_lvl;  // Current privilege level
	logic [1:0] io_priv;   // I/O privilege field
	logic       req;       // Bus request in progress
	assign priv_lvl = s.ctx[CTX_PRIV +: 2];
	assign io_priv  = s.flags[FB_IOPRIV +: 2];
	assign req  = WB_CYC_I && WB_STB_I && !s.ack;

	// Next-state logic
	always_comb begin
		logic        trap;
		logic        deny;
		logic        take;
		logic        evt;
		logic [31:0] f;
		trap   = 1'b0;
		deny   = 1'b0;
		take   = 1'b0;
		evt    = 1'b0;
		f      = 32'h0000_0000;
		next_s = s;
		// Bus answer, one cycle after request
		next_s.ack  = req;
		next_s.rdat = 32'h0000_0000;
		if (req && !WB_WE_I) begin
			case (WB_ADR_I)
				REG_FLAGS_LO: next_s.rdat = s.flags;
				REG_CTX:      next_s.rdat = {28'h000_0000, s.ctx};
				REG_IRQ_STAT: next_s.rdat = {29'h0000_0000, s.ist};
				REG_IRQ_EN:   next_s.rdat = {29'h0000_0000, s.ien};
				default:      next_s.rdat = 32'h0000_0000;
			endcase
		end
		// Bus writes
		if (req && WB_WE_I) begin
			case (WB_ADR_I)
				REG_FLAGS_LO: begin
					f = sel_merge(s.flags, WB_DAT_I, WB_SEL_I);
					next_s.flags = wr_flags(s.flags, f, s.ctx);
				end
				REG_CTX: begin
					f = sel_merge({28'h000_0000, s.ctx}, WB_DAT_I, WB_SEL_I);
					next_s.ctx = f[CTX_W-1:0];
				end
				REG_IRQ_CLR: begin
					if (WB_SEL_I[0]) begin
						next_s.ist = s.ist & ~WB_DAT_I[IRQ_W-1:0];
					end
				end
				REG_IRQ_EN: begin
					f = sel_merge({29'h0000_0000, s.ien}, WB_DAT_I, WB_SEL_I);
					next_s.ien = f[IRQ_W-1:0];
				end
				default: ;  // Read-only or unmapped
			endcase
		end
		// Pipeline write wins over bus write
		if (FLAG_WR) begin
			next_s.flags = wr_flags(s.flags, FLAG_WDATA, s.ctx);
		end
		// Result status flags
		if (STAT_WE) begin
			next_s.flags[FB_OVFL]   = STAT_VAL[5];
			next_s.flags[FB_SIGN]   = STAT_VAL[4];
			next_s.flags[FB_ZERO]   = STAT_VAL[3];
			next_s.flags[FB_AUX]    = STAT_VAL[2];
			next_s.flags[FB_PARITY] = STAT_VAL[1];
			next_s.flags[FB_CARRY]  = STAT_VAL[0];
		end
		// Trap uses the value before this instruction
		trap = RETIRE && s.flags[FB_STEP];
		// Port I/O check only
		deny = IO_REQ && (priv_lvl > io_priv);
		// Maskable interrupt gate
		take = EXT_INT && s.flags[FB_INTEN];
		// Unmaskable events plus the taken maskable interrupt
		evt = NMI_REQ || SWI_REQ || EXC_REQ || take;
		// Any delivery ends single stepping
		if (trap || deny || evt) begin
			next_s.flags[FB_STEP] = 1'b0;
		end
		// Event pulses
		next_s.dbg  = trap;
		next_s.gp   = deny;
		next_s.iog  = IO_REQ && !deny;
		next_s.iacc = take;
		next_s.dlv  = evt || trap || deny;
		// Sticky status, set wins over clear
		if (trap) begin
			next_s.ist[IRQ_DBG] = 1'b1;
		end
		if (deny) begin
			next_s.ist[IRQ_GP] = 1'b1;
		end
		if (take) begin
			next_s.ist[IRQ_INT] = 1'b1;
		end
		next_s.irq = |(next_s.ist & next_s.ien);
		// Sized view of the flags
		case (VIEW_SEL)
			FRC_VIEW16: next_s.view = {48'h0000_0000_0000, s.flags[15:0]};
			FRC_VIEW32: next_s.view = {32'h0000_0000, s.flags};
			default:    next_s.view = {32'h0000_0000, s.flags};
		endcase
	end

	// State register
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			s       <= '0;
			s.flags <= FLAGS_RESET;
			s.ctx   <= CTX_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs
	assign WB_ACK_O    = s.ack;
	assign WB_DAT_O    = s.rdat;
	assign FLAGS_VIEW  = s.view;
	assign DBG_EXC     = s.dbg;
	assign GP_FAULT    = s.gp;
	assign IO_GRANT    = s.iog;
	assign INT_ACCEPT  = s.iacc;
	assign EVT_DELIVER = s.dlv;
	assign IRQ         = s.irq;

	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	// Trap steps
	sequence step_armed;
		RETIRE && s.flags[FB_STEP];
	endsequence
	sequence step_trap;
		DBG_EXC && EVT_DELIVER && !s.flags[FB_STEP];
	endsequence

	trap_raise_a: assert property (step_armed |=> step_trap)
		else $error("single step trap missing");
	no_trap_a: assert property (RETIRE && !s.flags[FB_STEP] |=> !DBG_EXC)
		else $error("trap on setting instruction");
	tf_clear_a: assert property ((EXC_REQ || NMI_REQ || SWI_REQ) |=> !s.flags[FB_STEP])
		else $error("step enable survived event");
	int_mask_a: assert property (EXT_INT && !s.flags[FB_INTEN] |=> !INT_ACCEPT)
		else $error("masked interrupt taken");
	nmi_pass_a: assert property ((NMI_REQ || EXC_REQ || SWI_REQ) |=> EVT_DELIVER)
		else $error("unmaskable event lost");
	io_grant_a: assert property (IO_REQ && priv_lvl <= io_priv |=> IO_GRANT && !GP_FAULT)
		else $error("permitted I/O refused");
	io_deny_a: assert property (IO_REQ && priv_lvl > io_priv |=> GP_FAULT && !IO_GRANT)
		else $error("forbidden I/O allowed");
	resv_bits_a: assert property ((s.flags & ~FLAGS_RW_MASK) == FLAGS_ONE_MASK)
		else $error("reserved flag bits wrong");
	view16_a: assert property (VIEW_SEL == FRC_VIEW16 |=> FLAGS_VIEW ==
		{48'h0000_0000_0000, $past(s.flags[15:0])})
		else $error("16-bit view wrong");
	vif_redir_a: assert property (FLAG_WR && (s.ctx[CTX_VME] || s.ctx[CTX_PVI])
		&& io_priv != 2'h3 |=> $stable(s.flags[FB_INTEN]))
		else $error("real enable changed in virtual mode");
	wb_ack_a: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("bus ack not one cycle");

endmodule : frc_ctrl

// ### rtl/frc_pkg.sv
package frc_pkg;
	// Flag bit positions
	localparam int FB_CARRY  = 0;
	localparam int FB_ONE    = 1;
	localparam int FB_PARITY = 2;
	localparam int FB_AUX    = 4;
	localparam int FB_ZERO   = 6;
	localparam int FB_SIGN   = 7;
	localparam int FB_STEP   = 8;
	localparam int FB_INTEN  = 9;
	localparam int FB_DIR    = 10;
	localparam int FB_OVFL   = 11;
	localparam int FB_IOPRIV = 12;
	localparam int FB_NEST   = 14;
	localparam int FB_RESUME = 16;
	localparam int FB_V86    = 17;
	localparam int FB_ALIGN  = 18;
	localparam int FB_VINT   = 19;
	localparam int FB_VPEND  = 20;
	localparam int FB_IDENT  = 21;
	// Implemented bits, fixed-one bits, reset value
	localparam logic [31:0] FLAGS_RW_MASK  = 32'h003F_7FD5;
	localparam logic [31:0] FLAGS_ONE_MASK = 32'h0000_0002;
	localparam logic [31:0] FLAGS_RESET    = 32'h0000_0002;
	// Bits any privilege may write
	localparam logic [31:0] FLAGS_USR_MASK = 32'h003D_4DD5;
	// Register byte offsets
	localparam logic [7:0] REG_FLAGS_LO = 8'h00;
	localparam logic [7:0] REG_FLAGS_HI = 8'h04;
	localparam logic [7:0] REG_CTX      = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
	localparam logic [7:0] REG_IRQ_EN   = 8'h14;
	// Context register fields
	localparam int CTX_PRIV = 0;
	localparam int CTX_VME = 2;
	localparam int CTX_PVI = 3;
	localparam int CTX_W   = 4;
	localparam logic [CTX_W-1:0] CTX_RESET = 4'h0;
	// Interrupt status bits
	localparam int IRQ_DBG = 0;
	localparam int IRQ_GP  = 1;
	localparam int IRQ_INT = 2;
	localparam int IRQ_W   = 3;
	// Flags view width codes
	typedef enum logic [1:0] {
		FRC_VIEW16,
		FRC_VIEW32,
		FRC_VIEW64
	} frc_view_t;
endpackage : frc_pkg

// ### sim/frc_ctrl_tb_top.sv
`timescale 1ns/1ps
module frc_ctrl_tb_top;
	import frc_pkg::*;
	// Bench drive and observe
	logic        CLK, RESET_N, cyc, we;
	logic [7:0]  adr, req;
	logic [31:0] wdat, fdat, rdat, dout;
	logic [1:0]  view;
	logic [5:0]  sv, ans;
	logic [63:0] fview;
	logic        ack, dbg, gp, iog, inta, evt, irqo;
	int          err_total, checks_done;

	// Req: 0 retire,1 flag wr,2 stat,3 nmi,4 swi,5 exc,6 io,7 ext
	frc_ctrl frc_ctrl_i (.CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_ACK_O(ack),
		.WB_DAT_O(dout), .RETIRE(req[0]), .FLAG_WR(req[1]), .FLAG_WDATA(fdat),
		.STAT_WE(req[2]), .STAT_VAL(sv), .VIEW_SEL(view), .FLAGS_VIEW(fview),
		.EXT_INT(req[7]), .NMI_REQ(req[3]), .SWI_REQ(req[4]), .EXC_REQ(req[5]),
		.IO_REQ(req[6]), .DBG_EXC(dbg), .GP_FAULT(gp), .IO_GRANT(iog),
		.INT_ACCEPT(inta), .EVT_DELIVER(evt), .IRQ(irqo));

	// Clock, 50 ns period
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	// Compare and count
	task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One classic cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = dout;
		if (n >= 20) err_total++;
		cyc <= 1'b0;
	endtask : wb

	// Read and compare
	task rd(input string s, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(s, {32'h0000_0000, rdat}, {32'h0000_0000, e});
	endtask : rd

	// One-cycle request, answer seen one cycle later
	task pulse(input logic [7:0] m);
		@(posedge CLK) req <= m;
		@(posedge CLK) req <= 8'h00;
		@(posedge CLK) ans = {dbg, gp, iog, inta, evt, irqo};
	endtask : pulse

	// Verdict and stop
	task end_of_test;
		$display("mismatches %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// Watchdog, well past the run length
	initial begin
		#400_000;
		err_total++;
		end_of_test;
	end

	// Main sequence
	initial begin
		RESET_N = 1'b0;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		fdat = 32'h0000_0302;
		sv = 6'h3F;
		view = 2'h0;
		req = 8'h00;
		err_total = 0;
		checks_done = 0;
		repeat (3) @(posedge CLK);
		RESET_N <= 1'b1;
		rd("flags reset", 8'h00, 32'h0000_0002);
		rd("flags high", 8'h04, 32'h0000_0000);
		rd("unmapped", 8'h20, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'hFFFF_FFFF);
		rd("flags all", 8'h00, 32'h003F_7FD7);
		// Views of one register
		for (int v = 0; v < 3; v++) begin
			@(posedge CLK) view <= 2'(v);
			@(posedge CLK);
			@(posedge CLK) chk("view", fview, (v == 0) ? 64'h0000_0000_0000_7FD7
				: 64'h0000_0000_003F_7FD7);
		end
		$display("test done: reset and views");
		pulse(8'h01);
		chk("trap", ans[5:1], 5'b10001);
		rd("step off", 8'h00, 32'h003F_7ED7);
		pulse(8'h03);
		chk("no trap", ans[5], 1'b0);
		pulse(8'h80);
		chk("int take", ans[2], 1'b1);
		pulse(8'h01);
		chk("tf by int", ans[5], 1'b0);
		$display("test done: single step");
		wb(1'b1, 8'h00, 32'h0000_2202);
		// Port check at every privilege against field 2
		for (int c = 0; c < 4; c++) begin
			wb(1'b1, 8'h08, 32'(c));
			pulse(8'h40);
			chk("io", ans[4:3], (c <= 2) ? 2'b01 : 2'b10);
		end
		wb(1'b1, 8'h00, 32'h0000_0002);
		rd("if kept", 8'h00, 32'h0000_2202);
		wb(1'b1, 8'h08, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_2002);
		pulse(8'h80);
		chk("int masked", ans[2], 1'b0);
		wb(1'b1, 8'h08, 32'h0000_0004);
		wb(1'b1, 8'h00, 32'h0000_2202);
		rd("vme copy", 8'h00, 32'h0008_2002);
		// Unmaskable events with the enable clear
		for (int i = 3; i < 6; i++) begin
			pulse(8'(1 << i));
			chk("event", ans[1], 1'b1);
		end
		wb(1'b1, 8'h08, 32'h0000_0008);
		wb(1'b1, 8'h00, 32'h0000_2002);
		rd("pvi copy", 8'h00, 32'h0000_2002);
		$display("test done: privilege");
		wb(1'b1, 8'h08, 32'h0000_0000);
		pulse(8'h04);
		rd("status", 8'h00, 32'h0000_28D7);
		rd("events", 8'h0C, 32'h0000_0007);
		wb(1'b1, 8'h14, 32'h0000_0002);
		repeat (2) @(posedge CLK);
		chk("irq on", irqo, 1'b1);
		wb(1'b1, 8'h10, 32'h0000_0002);
		rd("cleared", 8'h0C, 32'h0000_0005);
		chk("irq off", irqo, 1'b0);
		$display("test done: interrupts");
		end_of_test;
	end
endmodule : frc_ctrl_tb_top
